/* hw/hub_config_power.sv */
// Functional notes
// - bit 7 of the second byte enables automatic self/bus power switching; 0 disables it.
// - with switching enabled, while local power is present the hub runs self-powered.
// - with switching enabled, local power is judged from the local supply sense input.
// - a change in local power at once drops downstream devices, their power, and upstream.
// - after that drop the hub re-attaches as bus-powered or self-powered per local power.
// - bits 5:4 pick the over-current filter delay of 0.1, 4, 8 or 16 ms.
// - bit 3 of the second byte reports the hub as part of a compound device.
// - with strap configuration, any non-removable port makes the hub report compound.
// - bit 3 of the third byte selects standard or port remap numbering.
// - bits 2:1 select indicator mode; 01 is speed indication, the rest USB mode.
// - indicator support is reported only in USB indicator mode.
// - bit 0 of the third byte enables string descriptor support.
// - mask bits 7:1 mark ports 7 to 1 non-removable and are reported to the host.
// - bit 0 of the non-removable mask always reads zero.
// - with default configuration the two strap pins choose the non-removable ports.
`timescale 1ns/10ps
`default_nettype none
module hub_config_power #(
  parameter int OC_CYCLES_0 = hub_cfg_pkg::OC_DELAY0_CYCLES,
  parameter int OC_CYCLES_1 = hub_cfg_pkg::OC_DELAY1_CYCLES,
  parameter int OC_CYCLES_2 = hub_cfg_pkg::OC_DELAY2_CYCLES,
  parameter int OC_CYCLES_3 = hub_cfg_pkg::OC_DELAY3_CYCLES
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  // configuration byte port from the eeprom loader or smbus slave
  input  wire logic                     cfg_wr,
  input  wire logic                     cfg_rd,
  input  wire logic [7:0]               cfg_addr,
  input  wire logic [7:0]               cfg_wdata,
  output logic [7:0]                    cfg_rdata,
  // default configuration straps
  input  wire logic                     strap_config,
  input  wire logic [1:0]               fixed_port_strap_pins,
  // power and over-current sensing
  input  wire logic                     local_supply_sense,
  input  wire logic                     overcurrent_sense,
  output logic                          overcurrent_detect,
  // toward the hub core
  output hub_cfg_pkg::hub_report_t      report,
  output hub_cfg_pkg::power_ctl_t       power_ctl
);
  import hub_cfg_pkg::*;

  typedef enum logic [0:0] {
    ST_RUN        = 1'b0,
    ST_DISCONNECT = 1'b1
  } pwr_state_t;

  logic [7:0]  byte_two_q;
  logic [7:0]  byte_three_q;
  logic [7:0]  fixed_mask_q;
  logic [7:0]  fixed_mask_eff;
  logic [7:0]  strap_mask;
  logic        compound_eff;
  logic [7:0]  rdata_d;
  logic [7:0]  rdata_q;
  pwr_state_t  state_q;
  logic        self_pwr_q;
  logic        local_prev_q;
  logic        started_q;
  logic [7:0]  hold_cnt_q;
  logic [17:0] oc_cnt_q;
  logic [17:0] oc_limit;
  logic        oc_det_q;
  logic        power_change;

  // configuration bytes, reserved bits masked on write
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      byte_two_q   <= RST_CONFIG_BYTE_TWO;
      byte_three_q <= RST_CONFIG_BYTE_THREE;
      fixed_mask_q <= RST_FIXED_PORT_MASK;
    end else if (cfg_wr) begin
      unique case (cfg_addr)
        OFS_CONFIG_BYTE_TWO:   byte_two_q   <= cfg_wdata & MASK_CONFIG_BYTE_TWO;
        OFS_CONFIG_BYTE_THREE: byte_three_q <= cfg_wdata & MASK_CONFIG_BYTE_THREE;
        OFS_FIXED_PORT_MASK:   fixed_mask_q <= cfg_wdata & MASK_FIXED_PORT;
        default: ;
      endcase
    end
  end

  // strap decode: 00 none, 01 port 1, 10 ports 1-2, 11 ports 1-3
  always_comb begin
    unique case (fixed_port_strap_pins)
      2'h0: strap_mask = 8'h00;
      2'h1: strap_mask = 8'h02;
      2'h2: strap_mask = 8'h06;
      2'h3: strap_mask = 8'h0E;
    endcase
  end

  // effective mask and compound flag
  assign fixed_mask_eff = strap_config ? strap_mask : fixed_mask_q;
  assign compound_eff   = strap_config ? (|strap_mask)
                                       : byte_two_q[BIT_COMPOUND];

  // readback of the stored bytes, captured the cycle of the read
  always_comb begin
    unique case (cfg_addr)
      OFS_CONFIG_BYTE_TWO:   rdata_d = byte_two_q;
      OFS_CONFIG_BYTE_THREE: rdata_d = byte_three_q;
      OFS_FIXED_PORT_MASK:   rdata_d = fixed_mask_eff;
      default:               rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (cfg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata = rdata_q;

  // report fields toward the hub core
  always_comb begin
    report.dynamic_en               = byte_two_q[BIT_DYNAMIC_EN];
    report.overcurrent_filter_delay = byte_two_q[BIT_OC_DELAY_LO +: 2];
    report.compound                 = compound_eff;
    report.port_renumber_enable     = byte_three_q[BIT_RENUMBER_EN];
    report.indicator_mode_select    = byte_three_q[BIT_INDICATOR_LO +: 2];
    report.indicators_supported     =
      (byte_three_q[BIT_INDICATOR_LO +: 2] != INDICATOR_SPEED);
    report.string_en                = byte_three_q[BIT_STRING_EN];
    report.fixed_device_port_mask   = fixed_mask_eff & MASK_FIXED_PORT;
  end

  // a local power change seen while dynamic switching is on
  assign power_change = started_q && byte_two_q[BIT_DYNAMIC_EN]
                        && (local_supply_sense != local_prev_q);

  // power state machine
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= ST_RUN;
      self_pwr_q   <= 1'b0;
      local_prev_q <= 1'b0;
      started_q    <= 1'b0;
      hold_cnt_q   <= 8'h00;
    end else begin
      local_prev_q <= local_supply_sense;
      if (!started_q) begin
        started_q  <= 1'b1;
        self_pwr_q <= local_supply_sense;
      end
      unique case (state_q)
        ST_RUN: begin
          if (power_change) begin
            state_q    <= ST_DISCONNECT;
            hold_cnt_q <= 8'(DISC_HOLD_CYCLES - 1);
          end
        end
        ST_DISCONNECT: begin
          if (hold_cnt_q == 8'h00) begin
            state_q    <= ST_RUN;
            self_pwr_q <= local_supply_sense;
          end else begin
            hold_cnt_q <= hold_cnt_q - 8'h01;
          end
        end
      endcase
    end
  end

  // link control: both connects and downstream power down while disconnected
  always_comb begin
    power_ctl.upstream_connect   = started_q && (state_q == ST_RUN);
    power_ctl.downstream_power   = started_q && (state_q == ST_RUN);
    power_ctl.downstream_connect = started_q && (state_q == ST_RUN);
    power_ctl.self_powered       = self_pwr_q;
  end

  // over-current filter limit from the delay field
  always_comb begin
    unique case (byte_two_q[BIT_OC_DELAY_LO +: 2])
      2'h0: oc_limit = 18'(OC_CYCLES_0);
      2'h1: oc_limit = 18'(OC_CYCLES_1);
      2'h2: oc_limit = 18'(OC_CYCLES_2);
      2'h3: oc_limit = 18'(OC_CYCLES_3);
    endcase
  end

  // over-current sense must hold for the whole filter delay
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      oc_cnt_q <= 18'h00000;
      oc_det_q <= 1'b0;
    end else if (!overcurrent_sense) begin
      oc_cnt_q <= 18'h00000;
      oc_det_q <= 1'b0;
    end else if (oc_cnt_q < oc_limit - 18'h00001) begin
      oc_cnt_q <= oc_cnt_q + 18'h00001;
    end else begin
      oc_det_q <= 1'b1;
    end
  end

  assign overcurrent_detect = oc_det_q;

  // assertions
  property p_no_switch_when_off;
    @(posedge mclk) disable iff (!reset_n)
    (state_q == ST_RUN && !byte_two_q[BIT_DYNAMIC_EN]) |=> (state_q == ST_RUN);
  endproperty
  a_no_switch_when_off: assert property (p_no_switch_when_off)
    else $error("power switch with dynamic switching off");

  property p_change_drops_link;
    @(posedge mclk) disable iff (!reset_n)
    (state_q == ST_RUN && started_q && byte_two_q[BIT_DYNAMIC_EN]
     && $changed(local_supply_sense))
    |=> (!power_ctl.upstream_connect && !power_ctl.downstream_power);
  endproperty
  a_change_drops_link: assert property (p_change_drops_link)
    else $error("link not dropped on local power change");

  property p_reattach_mode;
    @(posedge mclk) disable iff (!reset_n)
    (state_q == ST_DISCONNECT && hold_cnt_q == 8'h00)
    |=> (power_ctl.upstream_connect && power_ctl.self_powered == $past(local_supply_sense));
  endproperty
  a_reattach_mode: assert property (p_reattach_mode)
    else $error("re-attach in wrong power mode");

  property p_self_when_local;
    @(posedge mclk) disable iff (!reset_n)
    (power_ctl.upstream_connect && byte_two_q[BIT_DYNAMIC_EN]
     && local_supply_sense && $stable(local_supply_sense) && $stable(state_q))
    |-> power_ctl.self_powered;
  endproperty
  a_self_when_local: assert property (p_self_when_local)
    else $error("not self powered with local power present");

  // helper: consecutive over-current samples taken under the shortest delay
  logic [17:0] oc_run_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      oc_run_q <= 18'h00000;
    end else if (!overcurrent_sense || byte_two_q[BIT_OC_DELAY_LO +: 2] != 2'h0) begin
      oc_run_q <= 18'h00000;
    end else if (oc_run_q != 18'h3FFFF) begin
      oc_run_q <= oc_run_q + 18'h00001;
    end
  end

  property p_oc_fast;
    @(posedge mclk) disable iff (!reset_n)
    (oc_run_q >= 18'(OC_CYCLES_0)) |-> overcurrent_detect;
  endproperty
  a_oc_fast: assert property (p_oc_fast)
    else $error("over-current not flagged after short delay");

  property p_oc_not_early;
    @(posedge mclk) disable iff (!reset_n)
    $rose(overcurrent_sense) |=> !overcurrent_detect [*8];
  endproperty
  a_oc_not_early: assert property (p_oc_not_early)
    else $error("over-current flagged too early");

  property p_indicator_report;
    @(posedge mclk) disable iff (!reset_n)
    report.indicators_supported == (report.indicator_mode_select != INDICATOR_SPEED);
  endproperty
  a_indicator_report: assert property (p_indicator_report)
    else $error("indicator support misreported");

  property p_strap_compound;
    @(posedge mclk) disable iff (!reset_n)
    (strap_config && fixed_port_strap_pins != 2'h0) |-> report.compound;
  endproperty
  a_strap_compound: assert property (p_strap_compound)
    else $error("strapped fixed port without compound report");

  property p_mask_bit0;
    @(posedge mclk) disable iff (!reset_n)
    $past(cfg_rd) && $past(cfg_addr) == OFS_FIXED_PORT_MASK |-> cfg_rdata[0] == 1'b0;
  endproperty
  a_mask_bit0: assert property (p_mask_bit0)
    else $error("reserved mask bit reads one");

  property p_reserved_zero;
    @(posedge mclk) disable iff (!reset_n)
    $past(cfg_rd) && $past(cfg_addr) == OFS_CONFIG_BYTE_THREE |-> cfg_rdata[7:4] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits of third byte read nonzero");

  property p_reserved_two;
    @(posedge mclk) disable iff (!reset_n)
    $past(cfg_rd) && $past(cfg_addr) == OFS_CONFIG_BYTE_TWO
    |-> (cfg_rdata[6] == 1'b0 && cfg_rdata[2:0] == 3'h0);
  endproperty
  a_reserved_two: assert property (p_reserved_two)
    else $error("reserved bits of second byte read nonzero");

  property p_write_byte_two;
    @(posedge mclk) disable iff (!reset_n)
    (cfg_wr && cfg_addr == OFS_CONFIG_BYTE_TWO)
    |=> (report.dynamic_en == $past(cfg_wdata[7])
         && report.overcurrent_filter_delay == $past(cfg_wdata[5:4])
         && (strap_config || report.compound == $past(cfg_wdata[3])));
  endproperty
  a_write_byte_two: assert property (p_write_byte_two)
    else $error("second byte fields not reported after write");

  property p_write_byte_three;
    @(posedge mclk) disable iff (!reset_n)
    (cfg_wr && cfg_addr == OFS_CONFIG_BYTE_THREE)
    |=> (report.port_renumber_enable == $past(cfg_wdata[3])
         && report.indicator_mode_select == $past(cfg_wdata[2:1])
         && report.string_en == $past(cfg_wdata[0]));
  endproperty
  a_write_byte_three: assert property (p_write_byte_three)
    else $error("third byte fields not reported after write");

  property p_sense_only;
    @(posedge mclk) disable iff (!reset_n)
    (state_q == ST_RUN && !$changed(local_supply_sense)) |=> (state_q == ST_RUN);
  endproperty
  a_sense_only: assert property (p_sense_only)
    else $error("disconnect without a local power change");

  // helper: cycles spent in the disconnect hold
  logic [7:0] disc_len_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      disc_len_q <= 8'h00;
    end else if (state_q == ST_DISCONNECT) begin
      disc_len_q <= disc_len_q + 8'h01;
    end else begin
      disc_len_q <= 8'h00;
    end
  end

  property p_hold_not_long;
    @(posedge mclk) disable iff (!reset_n)
    (state_q == ST_DISCONNECT) |-> (disc_len_q < 8'(DISC_HOLD_CYCLES));
  endproperty
  a_hold_not_long: assert property (p_hold_not_long)
    else $error("disconnect hold too long");

  property p_hold_not_short;
    @(posedge mclk) disable iff (!reset_n)
    (state_q == ST_DISCONNECT && disc_len_q < 8'(DISC_HOLD_CYCLES - 1))
    |=> (state_q == ST_DISCONNECT);
  endproperty
  a_hold_not_short: assert property (p_hold_not_short)
    else $error("disconnect hold too short");

endmodule
`default_nettype wire

/* hw/hub_cfg_pkg.sv */
package hub_cfg_pkg;

  // register offsets
  localparam logic [7:0] OFS_CONFIG_BYTE_TWO   = 8'h07;
  localparam logic [7:0] OFS_CONFIG_BYTE_THREE = 8'h08;
  localparam logic [7:0] OFS_FIXED_PORT_MASK   = 8'h09;

  // field positions, second byte
  localparam int BIT_DYNAMIC_EN   = 7;
  localparam int BIT_OC_DELAY_LO  = 4;
  localparam int BIT_COMPOUND     = 3;
  // field positions, third byte
  localparam int BIT_RENUMBER_EN  = 3;
  localparam int BIT_INDICATOR_LO = 1;
  localparam int BIT_STRING_EN    = 0;

  // writable bits; everything else reads as zero
  localparam logic [7:0] MASK_CONFIG_BYTE_TWO   = 8'hB8;
  localparam logic [7:0] MASK_CONFIG_BYTE_THREE = 8'h0F;
  localparam logic [7:0] MASK_FIXED_PORT        = 8'hFE;

  // values after reset
  localparam logic [7:0] RST_CONFIG_BYTE_TWO   = 8'h00;
  localparam logic [7:0] RST_CONFIG_BYTE_THREE = 8'h00;
  localparam logic [7:0] RST_FIXED_PORT_MASK   = 8'h00;

  // indicator mode code that selects speed indication
  localparam logic [1:0] INDICATOR_SPEED = 2'h1;

  // timing
  localparam int CLK_KHZ           = 10000;
  localparam int OC_DELAY0_US      = 100;
  localparam int OC_DELAY1_US      = 4000;
  localparam int OC_DELAY2_US      = 8000;
  localparam int OC_DELAY3_US      = 16000;
  localparam int OC_DELAY0_CYCLES  = OC_DELAY0_US * CLK_KHZ / 1000;
  localparam int OC_DELAY1_CYCLES  = OC_DELAY1_US * CLK_KHZ / 1000;
  localparam int OC_DELAY2_CYCLES  = OC_DELAY2_US * CLK_KHZ / 1000;
  localparam int OC_DELAY3_CYCLES  = OC_DELAY3_US * CLK_KHZ / 1000;
  localparam int DISC_HOLD_US      = 10;
  localparam int DISC_HOLD_CYCLES  = DISC_HOLD_US * CLK_KHZ / 1000;

  // configuration as presented to the hub core
  typedef struct packed {
    logic       dynamic_en;
    logic [1:0] overcurrent_filter_delay;
    logic       compound;
    logic       port_renumber_enable;
    logic [1:0] indicator_mode_select;
    logic       indicators_supported;
    logic       string_en;
    logic [7:0] fixed_device_port_mask;
  } hub_report_t;

  // power link control toward the hub core
  typedef struct packed {
    logic upstream_connect;
    logic downstream_power;
    logic downstream_connect;
    logic self_powered;
  } power_ctl_t;

endpackage

/* tb/cfg_source.sv */
`timescale 1ns/10ps
`default_nettype none
module cfg_source (
  // clock
  input  wire logic       mclk,
  // byte port toward the hub
  output logic            cfg_wr,
  output logic            cfg_rd,
  output logic [7:0]      cfg_addr,
  output logic [7:0]      cfg_wdata,
  input  wire logic [7:0] cfg_rdata
);
  logic [7:0] mask_q;
  // idle port after power-up
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    mask_q = 8'h00;
  end
  // one byte cycle, launched after a falling edge and held over the taking edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge mclk);
    cfg_wr = w;
    cfg_rd = ~w;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge mclk);
    q = cfg_rdata;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = ~a;   // released lines do not keep the last value
    cfg_wdata = ~d;
  endtask
  // a compound declaration always comes with a fixed port marked
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    if (a == 8'h07 && d[3] && mask_q == 8'h00) begin
      xfer(1'b1, 8'h09, 8'h02, q);
      mask_q = 8'h02;
    end
    if (a == 8'h09) mask_q = d & 8'hFE;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask
endmodule
`default_nettype wire

/* tb/test_hub_config_power.sv */
`timescale 1ns/10ps
`default_nettype none
module test_hub_config_power;
  import hub_cfg_pkg::*;
  localparam int         OC_N [4]     = '{10, 20, 30, 40};
  localparam logic [7:0] STRAP_NR [4] = '{8'h00, 8'h02, 8'h06, 8'h0E};
  logic        mclk;
  logic        reset_n;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [7:0]  cfg_addr;
  logic [7:0]  cfg_wdata;
  logic [7:0]  cfg_rdata;
  logic        strap_config;
  logic [1:0]  fixed_port_strap_pins;
  logic        local_supply_sense;
  logic        overcurrent_sense;
  logic        overcurrent_detect;
  hub_report_t report;
  power_ctl_t  power_ctl;
  logic [7:0]  m2, m3, m9, r;
  int          err_count;
  int          n_checks;
  integer      seed;

  hub_config_power #(.OC_CYCLES_0(10), .OC_CYCLES_1(20), .OC_CYCLES_2(30), .OC_CYCLES_3(40))
    u_dut (.mclk(mclk), .reset_n(reset_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .strap_config(strap_config), .fixed_port_strap_pins(fixed_port_strap_pins),
    .local_supply_sense(local_supply_sense), .overcurrent_sense(overcurrent_sense),
    .overcurrent_detect(overcurrent_detect), .report(report), .power_ctl(power_ctl));
  cfg_source u_src (.mclk(mclk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));

  // clock
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // expected report from the model registers and straps
  function automatic hub_report_t exp_rep();
    logic [7:0] nr;
    nr = strap_config ? STRAP_NR[fixed_port_strap_pins] : m9;
    return {m2[7], m2[5:4], strap_config ? nr != 8'h00 : m2[3], m3[3], m3[2:1],
            m3[2:1] != 2'b01, m3[0], nr};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h07 && d[3] && m9 == 8'h00) m9 = 8'h02;
    case (a)
      8'h07: m2 = d & 8'hB8;
      8'h08: m3 = d & 8'h0F;
      8'h09: m9 = d & 8'hFE;
      default: ;
    endcase
    u_src.wr(a, d);
    chk(32'(report), 32'(exp_rep()), "report");
  endtask
  task automatic rdchk(input logic [7:0] a);
    logic [7:0] q;
    u_src.rd(a, q);
    chk(32'(q), a == 8'h07 ? m2 : a == 8'h08 ? m3 : a == 8'h09 ? exp_rep().fixed_device_port_mask
        : 8'h00, "readback");
  endtask
  // change local power and time the disconnect; bounce moves it again mid-hold
  task automatic switch_test(input logic s, input logic bounce);
    int low;
    low = 0;
    local_supply_sense = s;
    for (int c = 0; c < 300 && (low == 0 || power_ctl[3:1] == 3'b000); c++) begin
      @(negedge mclk);
      if (power_ctl[3:1] == 3'b000) low++;
      if (bounce && low == 40) local_supply_sense = ~s;
      if (bounce && low == 60) local_supply_sense = s;
    end
    chk(low, DISC_HOLD_CYCLES, "hold length");
    chk(32'(power_ctl), {28'h0, 3'b111, s}, "reattach");
    $display("test switch to %0d done", s);
  endtask

  // watchdog
  initial begin
    #5000000;
    err_count++;
    end_of_test();
  end

  initial begin
    {m2, m3, m9} = 24'h0;
    err_count = 0;
    n_checks = 0;
    seed = 32'hf90c;
    reset_n = 1'b0;
    strap_config = 1'b0;
    fixed_port_strap_pins = 2'b00;
    local_supply_sense = 1'b1;
    overcurrent_sense = 1'b0;
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk(32'(power_ctl), 32'h0F, "power after reset");
    for (int a = 7; a < 11; a++) rdchk(8'(a));
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      r = 8'($random(seed));
      wr(8'h09, r | 8'h02);
      wr(8'h07, 8'($random(seed)) & 8'h7F);
      wr(8'h08, {r[7:3], i[1:0], r[0]});
      wr(8'h20 + 8'(i), 8'($random(seed)));
      for (int a = 7; a < 10; a++) rdchk(8'(a));
      rdchk(8'h30 + 8'(i));
    end
    $display("test register access done");
    strap_config = 1'b1;
    for (int s = 0; s < 4; s++) begin
      fixed_port_strap_pins = 2'(s);
      @(negedge mclk);
      chk(32'(report), 32'(exp_rep()), "strap report");
      rdchk(8'h09);
    end
    strap_config = 1'b0;
    $display("test straps done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h07, 8'(k << 4));
      overcurrent_sense = 1'b1;
      repeat (OC_N[k] - 1) @(negedge mclk);
      overcurrent_sense = 1'b0;
      chk(32'(overcurrent_detect), 0, "oc early");
      @(negedge mclk);
      overcurrent_sense = 1'b1;
      repeat (OC_N[k] - 1) @(negedge mclk);
      chk(32'(overcurrent_detect), 0, "oc restart");
      @(negedge mclk);
      chk(32'(overcurrent_detect), 1, "oc detect");
      overcurrent_sense = 1'b0;
      @(negedge mclk);
      chk(32'(overcurrent_detect), 0, "oc clear");
    end
    $display("test overcurrent filter done");
    wr(8'h07, 8'h80);
    switch_test(1'b0, 1'b0);
    switch_test(1'b1, 1'b1);
    wr(8'h07, 8'h00);
    local_supply_sense = 1'b0;
    repeat (150) @(negedge mclk);
    chk(32'(power_ctl), 32'h0F, "no switching");
    $display("test switching disabled done");
    reset_n = 1'b0;
    {m2, m3, m9} = 24'h0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk(32'(power_ctl), 32'h0E, "power after second reset");
    for (int a = 7; a < 10; a++) rdchk(8'(a));
    $display("test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
